// File: hdl/sfpfe_top.sv
// Purpose: pin front end of a serial NOR flash, oversampled at 40 MHz
// Assumes: shift clock well below a quarter of the system clock
// Notes: instruction decoding and the array live behind the tx/rx regs
`timescale 1ns/100ps
module sfpfe_top import sfpfe_pkg::*; (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// wishbone classic slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// flash pins
	input wire logic i_chip_select_n,
	input wire logic i_shift_clock,
	input wire logic [3:0] i_data_line,
	output logic [3:0] o_data_line,
	output logic [3:0] o_data_line_oe,
	// internal protection view
	output logic o_status_write_allowed,
	output logic o_region_lock,
	output logic o_standby
);
	sfpfe_pins_s pins;
	logic [31:0] ctrl_q;
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic rx_valid_q;
	logic sclk_prev_q;
	logic cs_prev_q;
	logic armed_q;
	logic paused_q;
	logic pause_prev_q;
	logic [3:0] bitcnt_q;
	logic [3:0] dout_q;
	logic [3:0] oe_q;
	logic selected;
	logic rise;
	logic fall;
	logic qe;
	logic hw_lock;
	logic pause_n;
	logic [1:0] width;
	logic [3:0] step;
	logic wb_hit;
	logic [31:0] status_w;
	sfpfe_pins_s raw_pins;

	// ************************************************************
	// pin synchroniser
	// ************************************************************
	// raw pins bundled in carrier field order: cs_n, sclk, dq
	assign raw_pins = {i_chip_select_n, i_shift_clock, i_data_line};

	sfpfe_sync u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_pins(raw_pins),
		.o_pins(pins)
	);

	// bits moved per shift clock edge for a lane width
	function automatic logic [3:0] lane_step(input logic [1:0] w);
		unique case (w)
			SFPFE_W_DUAL: lane_step = 4'h2;
			SFPFE_W_QUAD: lane_step = 4'h4;
			default: lane_step = 4'h1;
		endcase
	endfunction

	// ************************************************************
	// decoded conditions
	// ************************************************************
	assign qe = ctrl_q[SFPFE_CTRL_QE];
	assign selected = ~pins.cs_n & armed_q;
	// protect pin loses its role with quad enable set
	assign hw_lock = ~qe & ~pins.dq[2] & ~ctrl_q[SFPFE_CTRL_LOCK_HI]
		& ctrl_q[SFPFE_CTRL_LOCK_LO];
	assign o_status_write_allowed = ~hw_lock;
	assign o_region_lock = hw_lock;
	// quad requested without quad enable falls back to single
	assign width = (ctrl_q[SFPFE_CTRL_WIDTH0+:2] == SFPFE_W_QUAD && !qe)
		? SFPFE_W_SINGLE : ctrl_q[SFPFE_CTRL_WIDTH0+:2];
	assign step = lane_step(width);
	// pause pin ignored entirely once it is a data line
	assign pause_n = qe | pins.dq[3];
	// edges count only while selected and not paused
	assign rise = selected & ~paused_q & pins.sclk & ~sclk_prev_q;
	assign fall = selected & ~paused_q & ~pins.sclk & sclk_prev_q;
	// standby only when idle inside
	assign o_standby = pins.cs_n & ~ctrl_q[SFPFE_CTRL_BUSY];

	// ************************************************************
	// edge history
	// ************************************************************
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			sclk_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
			pause_prev_q <= 1'b1;
		end else begin
			// tracked while deselected too, so either idle level is
			// already history at select time and gives no false edge
			sclk_prev_q <= pins.sclk;
			cs_prev_q <= pins.cs_n;
			pause_prev_q <= pause_n;
		end
	end

	// ************************************************************
	// power-up arming on the first select falling edge
	// ************************************************************
	// reset leaves the pin state unknown, so a high-to-low is demanded
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			armed_q <= 1'b0;
		end else if (cs_prev_q && !pins.cs_n) begin
			armed_q <= 1'b1;
		end
	end

	// ************************************************************
	// pause condition
	// ************************************************************
	// start and end both wait for a low shift clock; the level of the
	// pin is tracked so a deferred start or end resolves at that time
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || pins.cs_n) begin
			paused_q <= 1'b0;
		end else if (!pins.sclk) begin
			paused_q <= ~pause_n;
		end
	end

	// ************************************************************
	// bit position and input capture
	// ************************************************************
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || pins.cs_n) begin
			bitcnt_q <= SFPFE_BIT_RST;
		end else if (rise) begin
			// pause holds the count, so transfer resumes in place
			bitcnt_q <= (bitcnt_q + step >= 4'h8) ? SFPFE_BIT_RST
				: bitcnt_q + step;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rx_q <= 8'h00;
		end else if (rise && !ctrl_q[SFPFE_CTRL_DIR]) begin
			unique case (width)
				SFPFE_W_DUAL: rx_q <= {rx_q[5:0], pins.dq[1:0]};
				SFPFE_W_QUAD: rx_q <= {rx_q[3:0], pins.dq};
				default: rx_q <= {rx_q[6:0], pins.dq[0]};
			endcase
		end
	end

	// byte complete flag; the set wins over a software read-clear
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rx_valid_q <= 1'b0;
		end else if (rise && !ctrl_q[SFPFE_CTRL_DIR]
			&& bitcnt_q + step >= 4'h8) begin
			rx_valid_q <= 1'b1;
		end else if (wb_hit && !i_wb_we && i_wb_adr == SFPFE_OFF_RX) begin
			rx_valid_q <= 1'b0;
		end
	end

	// ************************************************************
	// output lanes, changed on falling shift clock edges
	// ************************************************************
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || pins.cs_n) begin
			dout_q <= 4'h0;
		end else if (fall && ctrl_q[SFPFE_CTRL_DIR]) begin
			unique case (width)
				SFPFE_W_DUAL: dout_q <= {2'b00,
					tx_q[3'(7 - bitcnt_q) -: 2]};
				SFPFE_W_QUAD: dout_q <= tx_q[3'(7 - bitcnt_q) -: 4];
				default: dout_q <= {2'b00, tx_q[3'(7 - bitcnt_q)],
					1'b0};
			endcase
		end
	end

	// drivers float whenever deselected or paused
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || !selected || paused_q || !ctrl_q[SFPFE_CTRL_DIR]) begin
			oe_q <= 4'h0;
		end else if (fall) begin
			unique case (width)
				SFPFE_W_DUAL: oe_q <= 4'h3;
				SFPFE_W_QUAD: oe_q <= 4'hf;
				default: oe_q <= 4'h2; // single read uses serial_out
			endcase
		end
	end

	assign o_data_line = dout_q;
	assign o_data_line_oe = oe_q;

	// ************************************************************
	// wishbone registers
	// ************************************************************
	assign wb_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;

	// busy bit lives in ctrl and is untouched by pause
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ctrl_q <= SFPFE_CTRL_RST;
			tx_q <= 8'h00;
		end else if (wb_hit && i_wb_we) begin
			if (i_wb_adr == SFPFE_OFF_CTRL && i_wb_sel[0]) begin
				ctrl_q[7:0] <= i_wb_dat[7:0];
			end
			if (i_wb_adr == SFPFE_OFF_TX && i_wb_sel[0]) begin
				tx_q <= i_wb_dat[7:0];
			end
		end
	end

	always_comb begin
		status_w = 32'h0;
		status_w[SFPFE_ST_SELECTED] = selected;
		status_w[SFPFE_ST_ARMED] = armed_q;
		status_w[SFPFE_ST_PAUSED] = paused_q;
		status_w[SFPFE_ST_STANDBY] = o_standby;
		status_w[SFPFE_ST_WPLOCK] = hw_lock;
		status_w[SFPFE_ST_RXVALID] = rx_valid_q;
		status_w[SFPFE_ST_BITCNT0+:4] = bitcnt_q;
	end

	// one-cycle answer; unmapped reads return zero
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end else begin
			o_wb_ack <= wb_hit;
			if (wb_hit && !i_wb_we) begin
				unique case (i_wb_adr)
					SFPFE_OFF_CTRL: o_wb_dat <= ctrl_q;
					SFPFE_OFF_STATUS: o_wb_dat <= status_w;
					SFPFE_OFF_TX: o_wb_dat <= {24'h0, tx_q};
					SFPFE_OFF_RX: o_wb_dat <= {24'h0, rx_q};
					default: o_wb_dat <= 32'h0;
				endcase
			end
		end
	end

endmodule

// File: pkg/sfpfe_pkg.sv
// Purpose: shared constants and carriers for the serial flash pin front end
// Assumes: 40 MHz system clock samples every pin
// Notes: register map sits on a classic Wishbone slave, 32-bit data
package sfpfe_pkg;

	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam logic [7:0] SFPFE_OFF_CTRL = 8'h00;
	localparam logic [7:0] SFPFE_OFF_STATUS = 8'h04;
	localparam logic [7:0] SFPFE_OFF_TX = 8'h08;
	localparam logic [7:0] SFPFE_OFF_RX = 8'h0c;

	// ************************************************************
	// control register fields and reset value
	// ************************************************************
	localparam int SFPFE_CTRL_LOCK_LO = 0; // status word one bit 7 copy
	localparam int SFPFE_CTRL_LOCK_HI = 1; // status word two bit 0 copy
	localparam int SFPFE_CTRL_QE = 2; // status word two bit 1 copy
	localparam int SFPFE_CTRL_BUSY = 3; // internal program/erase running
	localparam int SFPFE_CTRL_WIDTH0 = 4; // lane width field, 2 bits
	localparam int SFPFE_CTRL_DIR = 6; // 1: device drives lanes
	localparam logic [31:0] SFPFE_CTRL_RST = 32'h0000_0000;

	// ************************************************************
	// status register fields
	// ************************************************************
	localparam int SFPFE_ST_SELECTED = 0;
	localparam int SFPFE_ST_ARMED = 1;
	localparam int SFPFE_ST_PAUSED = 2;
	localparam int SFPFE_ST_STANDBY = 3;
	localparam int SFPFE_ST_WPLOCK = 4;
	localparam int SFPFE_ST_RXVALID = 5;
	localparam int SFPFE_ST_BITCNT0 = 8; // 4 bits

	localparam logic [1:0] SFPFE_SYNC_RST = 2'h3; // pins idle high
	localparam logic [3:0] SFPFE_BIT_RST = 4'h0;

	// lane widths of a transfer
	typedef enum logic [1:0] {
		SFPFE_W_SINGLE,
		SFPFE_W_DUAL,
		SFPFE_W_QUAD
	} sfpfe_width_e;

	// synchronised pin sample
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic [3:0] dq;
	} sfpfe_pins_s;

endpackage

// File: hdl/sfpfe_sync.sv
// Purpose: two-flop synchroniser for a bundle of pin inputs
// Assumes: pins are asynchronous to i_clk_sys
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
module sfpfe_sync import sfpfe_pkg::*; (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// raw and synchronised pins
	input wire sfpfe_pins_s i_pins,
	output sfpfe_pins_s o_pins
);
	sfpfe_pins_s meta_q;

	// ************************************************************
	// double register; idle-high reset avoids false select edges
	// ************************************************************
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			meta_q <= '{cs_n: 1'b1, sclk: 1'b0, dq: 4'hf};
			o_pins <= '{cs_n: 1'b1, sclk: 1'b0, dq: 4'hf};
		end else begin
			meta_q <= i_pins;
			o_pins <= meta_q;
		end
	end

endmodule

// File: dv/sfpfe_monitor.sv
// Purpose: port checks for sfpfe_top
// Assumes: pins come through a 2-flop sync
// Notes: windows allow for the sync delay
`timescale 1ns/100ps
module sfpfe_monitor import sfpfe_pkg::*; (
	// clock, reset and bus
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic o_wb_ack,
	// pins and protection view
	input wire logic i_chip_select_n,
	input wire logic i_shift_clock,
	input wire logic [3:0] i_data_line,
	input wire logic [3:0] o_data_line,
	input wire logic [3:0] o_data_line_oe,
	input wire logic o_status_write_allowed,
	input wire logic o_region_lock,
	input wire logic o_standby
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// a bus request is answered once, then ack drops
	sequence s_req; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
	sequence s_ack; o_wb_ack ##1 !o_wb_ack; endsequence
	property p_ack; s_req |=> s_ack; endproperty
	a_ack: assert property (p_ack) else $error("bus ack wrong");
	property p_ack_cause; o_wb_ack |-> $past(i_wb_stb); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
	property p_float; i_chip_select_n [*4] |-> o_data_line_oe == 4'h0;
	endproperty
	a_float: assert property (p_float) else $error("driven when idle");
	property p_active; !i_chip_select_n [*3] |-> !o_standby; endproperty
	a_active: assert property (p_active) else $error("standby selected");
	property p_sb_float; o_standby [*3] |-> o_data_line_oe == 4'h0;
	endproperty
	a_sb_float: assert property (p_sb_float) else $error("standby drives");
	property p_wp_high; i_data_line[2] [*3] |-> !o_region_lock; endproperty
	a_wp_high: assert property (p_wp_high) else $error("lock with pin high");
	property p_lock_pair; o_region_lock == !o_status_write_allowed;
	endproperty
	a_lock_pair: assert property (p_lock_pair) else $error("lock split");
	// a held-high clock has had no fresh fall, so data must stand
	property p_out_hold;
		(i_shift_clock && !i_chip_select_n) [*4] |-> $stable(o_data_line);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("data moved");
endmodule
bind sfpfe_top sfpfe_monitor u_mon (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
	.i_chip_select_n(i_chip_select_n), .i_shift_clock(i_shift_clock),
	.i_data_line(i_data_line), .o_data_line(o_data_line),
	.o_data_line_oe(o_data_line_oe), .o_standby(o_standby),
	.o_status_write_allowed(o_status_write_allowed),
	.o_region_lock(o_region_lock));

// File: dv/sfpfe_host.sv
// Purpose: host bus controller model on the flash pins
// Assumes: 40 MHz clock, shift clock 200 ns period
// Notes: lanes 2 and 3 idle high, like the pull-ups
`timescale 1ns/100ps
module sfpfe_host (
	// clock in, pins out
	input wire logic i_clk_sys,
	output logic o_cs_n,
	output logic o_sclk,
	output logic [3:0] o_dq
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_dq = 4'hf;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	// idle level picks mode 0 or 3; select always falls from high
	task automatic sel(input logic idle);
		tick(1);
		o_sclk <= idle;
		tick(2);
		o_cs_n <= 1'b0;
		tick(4);
	endtask
	task automatic desel();
		tick(1);
		o_cs_n <= 1'b1;
		o_dq <= 4'hf;
		tick(1);
		o_sclk <= 1'b0;
		tick(4);
	endtask
	// lanes settle in the low half, taken at the rise
	task automatic lane(input logic [3:0] v);
		tick(1);
		o_sclk <= 1'b0;
		o_dq <= v;
		tick(4);
		o_sclk <= 1'b1;
		tick(3);
	endtask
	task automatic pins(input logic [3:0] v);
		tick(1);
		o_dq <= v;
		tick(4);
	endtask
	task automatic low();
		tick(1);
		o_sclk <= 1'b0;
		tick(4);
	endtask
endmodule

// File: dv/sfpfe_tb.sv
// Purpose: self-checking bench for sfpfe_top
// Assumes: wishbone classic master, host pin model
// Notes: lane 1 gets inverted data when nobody reads it
`timescale 1ns/100ps
module sfpfe_tb import sfpfe_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [3:0] lanes = 4'h1;
	logic [7:0] txv = 8'h69;
	logic [31:0] rdat, q, sv;
	logic ack, swa, rlock, stby, cs_n, sclk;
	logic [3:0] hdq, dout, doe, dl;
	logic [7:0] cv [4] = '{8'h00, 8'h10, 8'h20, 8'h24};
	logic [7:0] bv [4] = '{8'ha5, 8'h4e, 8'h3c, 8'h96};
	int wv [4] = '{1, 2, 1, 4};
	int mismatches = 0;
	int n_checks = 0;
	always #12.5 clk = ~clk;
	// driven lanes win over the host
	assign dl = (doe & dout) | (~doe & hdq);
	sfpfe_top DUT (.i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(lanes),
		.i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_chip_select_n(cs_n), .i_shift_clock(sclk), .i_data_line(dl),
		.o_data_line(dout), .o_data_line_oe(doe),
		.o_status_write_allowed(swa), .o_region_lock(rlock),
		.o_standby(stby));
	sfpfe_host u_host (.i_clk_sys(clk), .o_cs_n(cs_n), .o_sclk(sclk),
		.o_dq(hdq));
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask
	// request stands until ack is sampled high at a rising edge;
	// only the watchdog ends a wait that never gets an answer
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, q & m, e);
	endtask
	// msb first, w lanes per shift clock
	task automatic shift(input logic [7:0] b, input int w);
		for (int i = 8 - w; i >= 0; i -= w) begin
			if (w == 1)
				u_host.lane({2'h3, ~b[i], b[i]});
			else if (w == 2)
				u_host.lane({2'h3, b[i+:2]});
			else
				u_host.lane(b[i+:4]);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		test_done();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(SFPFE_OFF_CTRL, 32'hffffffff, SFPFE_CTRL_RST, "ctrl");
		rd(SFPFE_OFF_STATUS, 32'hf3f, 32'h8, "status");
		rd(8'h10, 32'hffffffff, 32'h0, "unmapped");
		// a write with byte lane 0 off must leave ctrl alone
		lanes <= 4'h0;
		wb(1'b1, SFPFE_OFF_CTRL, 32'h04);
		lanes <= 4'h1;
		rd(SFPFE_OFF_CTRL, 32'hffffffff, 32'h0, "lane_off");
		u_host.sel(1'b0);
		rd(SFPFE_OFF_STATUS, 32'h0f, 32'h3, "armed");
		u_host.desel();
		// every lane width, both clock modes
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, SFPFE_OFF_CTRL, {24'h0, cv[k]});
			u_host.sel(k[0]);
			shift(bv[k], wv[k]);
			rd(SFPFE_OFF_STATUS, 32'h20, 32'h20, "rxvalid");
			rd(SFPFE_OFF_RX, 32'hff, {24'h0, bv[k]}, "rx");
			u_host.desel();
		end
		// reading rx cleared the byte flag
		rd(SFPFE_OFF_STATUS, 32'h20, 32'h0, "rxclr");
		// mode 3 read: each fall puts the next bit, msb first, on lane 1
		wb(1'b1, SFPFE_OFF_TX, {24'h0, txv});
		wb(1'b1, SFPFE_OFF_CTRL, 32'h40);
		u_host.sel(1'b1);
		for (int i = 7; i >= 0; i--) begin
			u_host.lane(4'hf);
			@(negedge clk);
			chk("dout", {31'h0, dout[1]}, {31'h0, txv[i]});
		end
		chk("oe_read", {28'h0, doe}, 32'h2);
		u_host.desel();
		@(negedge clk);
		chk("oe_idle", {28'h0, doe}, 32'h0);
		wb(1'b1, SFPFE_OFF_CTRL, 32'h01);
		u_host.pins(4'hb);
		@(negedge clk);
		chk("lock", {30'h0, swa, rlock}, 32'h1);
		rd(SFPFE_OFF_STATUS, 32'h10, 32'h10, "wplock");
		wb(1'b1, SFPFE_OFF_CTRL, 32'h05);
		@(negedge clk);
		chk("qe_unlock", {30'h0, swa, rlock}, 32'h2);
		wb(1'b1, SFPFE_OFF_CTRL, 32'h08);
		u_host.sel(1'b0);
		u_host.pins(4'h7);
		wb(1'b0, SFPFE_OFF_STATUS, 32'h0);
		sv = q;
		chk("pause", sv & 32'h4, 32'h4);
		u_host.lane(4'h7);
		u_host.pins(4'hf);
		rd(SFPFE_OFF_STATUS, 32'hf04, (sv & 32'hf00) | 32'h4, "frozen");
		u_host.low();
		rd(SFPFE_OFF_STATUS, 32'h4, 32'h0, "resume");
		u_host.desel();
		@(negedge clk);
		chk("busy", {31'h0, stby}, 32'h0);
		wb(1'b1, SFPFE_OFF_CTRL, 32'h00);
		@(negedge clk);
		chk("standby", {31'h0, stby}, 32'h1);
		test_done();
	end
endmodule
